/* File: pkg/dcpid_defines.svh */
// Constants of the DC motor position PID regulator
`ifndef DCPID_DEFINES_SVH
`define DCPID_DEFINES_SVH

// ==========================================================
// Register offsets (byte addresses)
`define DCPID_REG_CTRL      8'h00
`define DCPID_REG_PGAIN     8'h04
`define DCPID_REG_IGAIN     8'h08
`define DCPID_REG_DGAIN     8'h0C
`define DCPID_REG_UNOM      8'h10
`define DCPID_REG_CPR       8'h14
`define DCPID_REG_TARGET    8'h18
`define DCPID_REG_SPEED     8'h1C
`define DCPID_REG_RUNPOS    8'h20
`define DCPID_REG_MEASPOS   8'h24
`define DCPID_REG_DUTY      8'h28
`define DCPID_REG_STATUS    8'h2C

// ==========================================================
// Field positions and reset values
`define DCPID_CTRL_EN_BIT   0
`define DCPID_CTRL_STOP_BIT 1
`define DCPID_STAT_DONE_BIT 0
`define DCPID_STAT_SAT_BIT  1
`define DCPID_STAT_DIR_BIT  2
`define DCPID_RST_GAIN      16'h0000
`define DCPID_RST_UNOM      16'h2EE0
`define DCPID_RST_CPR       16'h0400
`define DCPID_RST_SPEED     32'h0000_0000

// ==========================================================
// Scaling: duty is a Q16 fraction
`define DCPID_FRAC_W        16
`define DCPID_P_FULL_REV    256
`define DCPID_I_FULL_MREV_S 52500
`define DCPID_D_FULL_RPM    96000
`define DCPID_SEC_PER_MIN   60
`define DCPID_NS_PER_S      1000000000
`define DCPID_NS_PER_MS     1000000
`define DCPID_ERR_W         24
`define DCPID_INT_W         30
`define DCPID_DER_W         16
`define DCPID_MAG_W         48

// ==========================================================
// Timing
`define DCPID_CLK_PERIOD_NS  10
`define DCPID_PWM_PERIOD_NS  25600
`define DCPID_LOOP_PERIOD_NS 1000000
`define DCPID_PWM_CYC (`DCPID_PWM_PERIOD_NS / `DCPID_CLK_PERIOD_NS)
`define DCPID_LOOP_CYC (`DCPID_LOOP_PERIOD_NS / `DCPID_CLK_PERIOD_NS)

`endif

/* File: pkg/dcpid_pkg.sv */
// Types shared by the DC motor position PID regulator
package dcpid_pkg;

  typedef logic signed [31:0] dcpid_pos_t;
  typedef logic signed [63:0] dcpid_term_t;

  // Regulator gains, unsigned 0..65535
  typedef struct packed {
    logic [15:0] p;
    logic [15:0] i;
    logic [15:0] d;
  } dcpid_gains_s;

  // One loop update sequence
  typedef enum logic [2:0] {
    DCPID_ST_IDLE  = 3'b000,
    DCPID_ST_TERMS = 3'b001,
    DCPID_ST_SUM   = 3'b010,
    DCPID_ST_DIV   = 3'b011,
    DCPID_ST_APPLY = 3'b100
  } dcpid_state_e;

endpackage

/* File: design/dcpid_divider.sv */
// Sequential restoring divider for duty normalization
module dcpid_divider #(
  parameter int unsigned NW = 64,
  parameter int unsigned DW = 32
)(
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          ce_i,
  input  wire logic          start_i,
  input  wire logic [NW-1:0] num_i,
  input  wire logic [DW-1:0] den_i,
  output logic               done_o,
  output logic [NW-1:0]      quo_o
);

  localparam int unsigned CW = $clog2(NW + 1);

  logic [DW:0]   rem_r;
  logic [DW-1:0] den_r;
  logic [CW-1:0] cnt_r;
  logic          busy_r;
  logic [DW:0]   rem_sh;

  // Shifted remainder for the next step
  assign rem_sh = {rem_r[DW-1:0], quo_o[NW-1]};

  // One quotient bit per cycle; zero divisor gives all ones
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rem_r  <= '0;
      den_r  <= '0;
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_o <= 1'b0;
      quo_o  <= '0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (start_i) begin
        rem_r  <= '0;
        den_r  <= den_i;
        quo_o  <= num_i;
        cnt_r  <= CW'(NW);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (rem_sh >= {1'b0, den_r}) begin
          rem_r <= rem_sh - {1'b0, den_r};
          quo_o <= {quo_o[NW-2:0], 1'b1};
        end else begin
          rem_r <= rem_sh;
          quo_o <= {quo_o[NW-2:0], 1'b0};
        end
        cnt_r <= cnt_r - CW'(1);
        if (cnt_r == CW'(1)) begin
          busy_r <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

endmodule

/* File: design/dcpid_regulator.sv */
// DC motor position PID regulator with encoder and PWM
//
// Chosen here: the address-and-strobe port and the address map.
`include "dcpid_defines.svh"

module dcpid_regulator
  import dcpid_pkg::*;
#(
  parameter int unsigned LOOP_CYC = `DCPID_LOOP_CYC,
  parameter int unsigned PWM_CYC  = `DCPID_PWM_CYC,
  parameter int unsigned AW       = 8
)(
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          ce_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [31:0]   wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  input  wire logic          enc_a_i,
  input  wire logic          enc_b_i,
  input  wire logic [15:0]   supply_mv_i,
  input  wire logic          limit_stop_i,
  output logic [31:0]        rdata_o,
  output logic               pwm_o,
  output logic               dir_o,
  output logic               move_done_o
);

  // ==========================================================
  // Scaling constants
  localparam int FW = `DCPID_FRAC_W;
  localparam dcpid_term_t P_K =
    64'((64'd1 << FW) / `DCPID_P_FULL_REV);
  localparam dcpid_term_t I_K =
    64'(((64'd1 << (2 * FW)) * `DCPID_LOOP_PERIOD_NS)
        / (64'(`DCPID_I_FULL_MREV_S) * `DCPID_NS_PER_MS));
  localparam dcpid_term_t D_K =
    64'(((64'd1 << FW) * `DCPID_SEC_PER_MIN * 64'(`DCPID_NS_PER_S))
        / (64'(`DCPID_D_FULL_RPM) * `DCPID_LOOP_PERIOD_NS));
  localparam logic [16:0] DUTY_FULL = 17'h1_0000;
  localparam int EW = `DCPID_ERR_W;
  localparam int IW = `DCPID_INT_W;
  localparam int DRW = `DCPID_DER_W;
  localparam int MW = `DCPID_MAG_W;
  localparam int LCW = $clog2(LOOP_CYC + 1);
  localparam int PCW = $clog2(PWM_CYC + 1);
  localparam logic signed [EW-1:0] ERR_MAX = {1'b0, {(EW-1){1'b1}}};
  localparam logic signed [EW-1:0] ERR_MIN = {1'b1, {(EW-1){1'b0}}};
  localparam logic signed [IW-1:0] INT_MAX = {1'b0, {(IW-1){1'b1}}};
  localparam logic signed [IW-1:0] INT_MIN = {1'b1, {(IW-1){1'b0}}};
  localparam logic signed [DRW-1:0] DER_MAX = {1'b0, {(DRW-1){1'b1}}};
  localparam logic signed [DRW-1:0] DER_MIN = {1'b1, {(DRW-1){1'b0}}};

  // ==========================================================
  // Software state
  logic         enable_r;
  dcpid_gains_s gains_r;
  logic [15:0]  unom_r;
  logic [15:0]  cpr_r;
  dcpid_pos_t   target_r;
  logic [31:0]  speed_r;

  // ==========================================================
  // Loop state
  dcpid_state_e      state_r;
  dcpid_pos_t        run_pos_r;
  dcpid_pos_t        meas_pos_r;
  logic [1:0]        enc_prev_r;
  logic              enc_vld_r;
  logic [LCW-1:0]    loop_cnt_r;
  logic              tick_r;
  logic signed [EW-1:0]  err_r;
  logic signed [EW-1:0]  err_prev_r;
  logic signed [IW-1:0]  integ_r;
  logic signed [DRW-1:0] deriv_r;
  dcpid_term_t       p_term_r;
  dcpid_term_t       i_term_r;
  dcpid_term_t       d_term_r;
  logic              neg_r;
  logic              sat_r;
  logic [16:0]       duty_r;
  logic [PCW-1:0]    thr_r;
  logic [PCW-1:0]    pwm_cnt_r;
  logic [63:0]       num_r;
  logic [31:0]       den_r;
  logic              div_go_r;
  logic              div_done;
  logic [63:0]       div_quo;

  // ==========================================================
  // Combinational helpers
  logic        hard_stop;
  logic        enc_fwd;
  logic        enc_rev;
  dcpid_pos_t  to_go;
  dcpid_pos_t  err_full;
  logic signed [IW:0]  integ_sum;
  logic signed [EW:0]  der_full;
  dcpid_term_t act_sum;
  logic [63:0] act_mag;
  logic [MW-1:0] mag_sat;

  // Stop by software or limit switch freezes the setpoint
  assign hard_stop = (wr_i && addr_i == `DCPID_REG_CTRL
                      && wdata_i[`DCPID_CTRL_STOP_BIT])
                     || limit_stop_i;

  // Quadrature step decode, 4 counts per line
  always_comb begin
    enc_fwd = 1'b0;
    enc_rev = 1'b0;
    unique case ({enc_prev_r, enc_a_i, enc_b_i})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: enc_fwd = enc_vld_r;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: enc_rev = enc_vld_r;
      default: ;
    endcase
  end

  // Error, integral and derivative candidates
  assign to_go    = target_r - run_pos_r;
  assign err_full = run_pos_r - meas_pos_r;
  assign integ_sum = IW'(integ_r) + (IW + 1)'(err_r);
  assign der_full  = (EW + 1)'(err_r) - (EW + 1)'(err_prev_r);

  // Action sum and its magnitude, limited before scaling
  assign act_sum = p_term_r + i_term_r + d_term_r;
  assign act_mag = act_sum[63] ? 64'(-act_sum) : 64'(act_sum);
  assign mag_sat = (act_mag > 64'({MW{1'b1}}))
                   ? {MW{1'b1}} : act_mag[MW-1:0];

  // ==========================================================
  // Register writes
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      enable_r <= 1'b0;
      gains_r  <= '{p: `DCPID_RST_GAIN, i: `DCPID_RST_GAIN,
                    d: `DCPID_RST_GAIN};
      unom_r   <= `DCPID_RST_UNOM;
      cpr_r    <= `DCPID_RST_CPR;
      speed_r  <= `DCPID_RST_SPEED;
    end else if (ce_i && wr_i) begin
      unique case (addr_i)
        `DCPID_REG_CTRL:  enable_r  <= wdata_i[`DCPID_CTRL_EN_BIT];
        `DCPID_REG_PGAIN: gains_r.p <= wdata_i[15:0];
        `DCPID_REG_IGAIN: gains_r.i <= wdata_i[15:0];
        `DCPID_REG_DGAIN: gains_r.d <= wdata_i[15:0];
        `DCPID_REG_UNOM:  unom_r    <= wdata_i[15:0];
        `DCPID_REG_CPR:   cpr_r     <= wdata_i[15:0];
        `DCPID_REG_SPEED: speed_r   <= wdata_i;
        default: ;
      endcase
    end
  end

  // Target; a hard stop pins it to the running position
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      target_r <= '0;
    end else if (ce_i) begin
      if (hard_stop) begin
        target_r <= run_pos_r;
      end else if (wr_i && addr_i == `DCPID_REG_TARGET) begin
        target_r <= wdata_i;
      end
    end
  end

  // ==========================================================
  // Register reads, data only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      rdata_o <= '0;
      if (rd_i) begin
        unique case (addr_i)
          `DCPID_REG_CTRL:    rdata_o <= 32'(enable_r);
          `DCPID_REG_PGAIN:   rdata_o <= 32'(gains_r.p);
          `DCPID_REG_IGAIN:   rdata_o <= 32'(gains_r.i);
          `DCPID_REG_DGAIN:   rdata_o <= 32'(gains_r.d);
          `DCPID_REG_UNOM:    rdata_o <= 32'(unom_r);
          `DCPID_REG_CPR:     rdata_o <= 32'(cpr_r);
          `DCPID_REG_TARGET:  rdata_o <= target_r;
          `DCPID_REG_SPEED:   rdata_o <= speed_r;
          `DCPID_REG_RUNPOS:  rdata_o <= run_pos_r;
          `DCPID_REG_MEASPOS: rdata_o <= meas_pos_r;
          `DCPID_REG_DUTY:    rdata_o <= 32'(duty_r);
          `DCPID_REG_STATUS: begin
            rdata_o[`DCPID_STAT_DONE_BIT] <= move_done_o;
            rdata_o[`DCPID_STAT_SAT_BIT]  <= sat_r;
            rdata_o[`DCPID_STAT_DIR_BIT]  <= dir_o;
          end
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Encoder position counter
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      enc_prev_r <= 2'b00;
      enc_vld_r  <= 1'b0;
      meas_pos_r <= '0;
    end else if (ce_i) begin
      enc_prev_r <= {enc_a_i, enc_b_i};
      enc_vld_r  <= 1'b1;
      if (enc_fwd) begin
        meas_pos_r <= meas_pos_r + 32'sd1;
      end else if (enc_rev) begin
        meas_pos_r <= meas_pos_r - 32'sd1;
      end
    end
  end

  // Loop update tick
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      loop_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else if (ce_i) begin
      tick_r <= (loop_cnt_r == LCW'(LOOP_CYC - 1));
      if (loop_cnt_r == LCW'(LOOP_CYC - 1)) begin
        loop_cnt_r <= '0;
      end else begin
        loop_cnt_r <= loop_cnt_r + LCW'(1);
      end
    end
  end

  // Running position walks toward the target each tick
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      run_pos_r <= '0;
    end else if (ce_i && tick_r && !hard_stop) begin
      if (to_go[31] ? (-to_go <= $signed(speed_r))
                    : (to_go <= $signed(speed_r))) begin
        run_pos_r <= target_r;
      end else if (to_go[31]) begin
        run_pos_r <= run_pos_r - $signed(speed_r);
      end else begin
        run_pos_r <= run_pos_r + $signed(speed_r);
      end
    end
  end

  // Move done once the shaft sits on the final target
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      move_done_o <= 1'b0;
    end else if (ce_i) begin
      move_done_o <= (run_pos_r == target_r)
                     && (meas_pos_r == target_r);
    end
  end

  // ==========================================================
  // Loop sequence: sample, terms, sum, divide, apply
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r    <= DCPID_ST_IDLE;
      err_r      <= '0;
      err_prev_r <= '0;
      integ_r    <= '0;
      deriv_r    <= '0;
      p_term_r   <= '0;
      i_term_r   <= '0;
      d_term_r   <= '0;
      neg_r      <= 1'b0;
      num_r      <= '0;
      den_r      <= '0;
      div_go_r   <= 1'b0;
    end else if (ce_i) begin
      div_go_r <= 1'b0;
      unique case (state_r)
        DCPID_ST_IDLE: begin
          if (!enable_r) begin
            integ_r    <= '0;
            err_prev_r <= '0;
          end else if (tick_r) begin
            // Clamp error to the product width
            if (err_full > 32'(ERR_MAX)) begin
              err_r <= ERR_MAX;
            end else if (err_full < 32'(ERR_MIN)) begin
              err_r <= ERR_MIN;
            end else begin
              err_r <= err_full[EW-1:0];
            end
            err_prev_r <= err_r;
            state_r    <= DCPID_ST_TERMS;
          end
        end
        DCPID_ST_TERMS: begin
          // Integral and rate of change, both clamped
          if (integ_sum > (IW + 1)'(INT_MAX)) begin
            integ_r <= INT_MAX;
          end else if (integ_sum < (IW + 1)'(INT_MIN)) begin
            integ_r <= INT_MIN;
          end else begin
            integ_r <= integ_sum[IW-1:0];
          end
          if (der_full > (EW + 1)'(DER_MAX)) begin
            deriv_r <= DER_MAX;
          end else if (der_full < (EW + 1)'(DER_MIN)) begin
            deriv_r <= DER_MIN;
          end else begin
            deriv_r <= der_full[DRW-1:0];
          end
          p_term_r <= $signed({1'b0, gains_r.p}) * err_r
                      * P_K;
          state_r  <= DCPID_ST_SUM;
        end
        DCPID_ST_SUM: begin
          i_term_r <= ($signed({1'b0, gains_r.i}) * integ_r
                       * I_K) >>> FW;
          d_term_r <= $signed({1'b0, gains_r.d}) * deriv_r
                      * D_K;
          state_r  <= DCPID_ST_DIV;
        end
        DCPID_ST_DIV: begin
          // Normalize by nominal, supply and resolution
          neg_r    <= act_sum[63];
          num_r    <= 64'(mag_sat) * 64'(unom_r);
          den_r    <= 32'(supply_mv_i) * 32'(cpr_r);
          div_go_r <= 1'b1;
          state_r  <= DCPID_ST_APPLY;
        end
        DCPID_ST_APPLY: begin
          if (div_done) begin
            state_r <= DCPID_ST_IDLE;
          end
        end
        default: state_r <= DCPID_ST_IDLE;
      endcase
    end
  end

  // Normalizing divider
  dcpid_divider #(
    .NW (64),
    .DW (32)
  ) u_div (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .start_i (div_go_r),
    .num_i   (num_r),
    .den_i   (den_r),
    .done_o  (div_done),
    .quo_o   (div_quo)
  );

  // ==========================================================
  // Duty, polarity and PWM threshold
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      duty_r <= '0;
      thr_r  <= '0;
      dir_o  <= 1'b0;
      sat_r  <= 1'b0;
    end else if (ce_i) begin
      if (!enable_r) begin
        duty_r <= '0;
        thr_r  <= '0;
        sat_r  <= 1'b0;
      end else if (state_r == DCPID_ST_APPLY && div_done) begin
        dir_o <= neg_r;
        if (div_quo > 64'(DUTY_FULL)) begin
          duty_r <= DUTY_FULL;
          thr_r  <= PCW'(PWM_CYC);
          sat_r  <= 1'b1;
        end else begin
          duty_r <= div_quo[16:0];
          thr_r  <= PCW'((64'(div_quo[16:0]) * 64'(PWM_CYC)) >> FW);
          sat_r  <= 1'b0;
        end
      end
    end
  end

  // PWM generator drives the winding
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pwm_cnt_r <= '0;
      pwm_o     <= 1'b0;
    end else if (ce_i) begin
      if (pwm_cnt_r == PCW'(PWM_CYC - 1)) begin
        pwm_cnt_r <= '0;
      end else begin
        pwm_cnt_r <= pwm_cnt_r + PCW'(1);
      end
      pwm_o <= (pwm_cnt_r < thr_r);
    end
  end

endmodule

/* File: tb/dcpid_regulator_checker.sv */
// Checker of bus, reset and output timing of the regulator
module dcpid_regulator_checker #(
  parameter int unsigned LOOP_CYC = 200,
  parameter int unsigned PWM_CYC  = 16,
  parameter int unsigned AW       = 8
)(
  input wire logic          clk_i,
  input wire logic          rst_n_i,
  input wire logic          ce_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [31:0]   wdata_i,
  input wire logic          wr_i,
  input wire logic          rd_i,
  input wire logic          enc_a_i,
  input wire logic          enc_b_i,
  input wire logic [15:0]   supply_mv_i,
  input wire logic          limit_stop_i,
  input wire logic [31:0]   rdata_o,
  input wire logic          pwm_o,
  input wire logic          dir_o,
  input wire logic          move_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        en_r;
  logic [31:0] dis_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // Mirror of the enable bit
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) en_r <= 1'b0;
    else if (ce_i && wr_i && addr_i == AW'(8'h00)) en_r <= wdata_i[0];
  end
  // Cycles spent disabled, saturating
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || en_r) dis_r <= '0;
    else if (ce_i && dis_r < 32'h0000_FFFF) dis_r <= dis_r + 32'h1;
  end
  sequence s_rd(a);
    ce_i && rd_i && addr_i == a;
  endsequence
  sequence s_release;
    !rst_n_i ##1 rst_n_i ##1 rst_n_i;
  endsequence
  a_rdata_idle: assert property (
    !(ce_i && rd_i) |=> rdata_o == 32'h0) else $error("rdata not idle");
  a_unmapped_zero: assert property (
    ce_i && rd_i && addr_i > AW'(8'h2C) |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_readback: assert property (
    s_rd(AW'(8'h00)) |=> rdata_o == {31'h0, en_r})
    else $error("ctrl readback wrong");
  a_gain_upper: assert property (
    s_rd(AW'(8'h04)) |=> rdata_o[31:16] == 16'h0)
    else $error("gain upper bits set");
  a_reset_quiet: assert property (disable iff (1'b0)
    !rst_n_i |=> !pwm_o && !dir_o && rdata_o == 32'h0)
    else $error("outputs active in reset");
  a_done_release: assert property (disable iff (1'b0)
    s_release |-> move_done_o)
    else $error("done low after reset");
  a_ce_freeze: assert property (
    !ce_i |=> $stable(pwm_o) && $stable(dir_o) && $stable(move_done_o))
    else $error("outputs moved while frozen");
  a_off_no_pwm: assert property (
    dis_r > LOOP_CYC + 2 * PWM_CYC + 100 |-> !pwm_o)
    else $error("pwm while disabled");
endmodule

/* File: tb/dcpid_motor_model.sv */
// Winding load and quadrature encoder model
module dcpid_motor_model (
  input  wire logic  clk_i,
  input  wire logic  step_i,
  input  wire logic  up_i,
  input  wire logic  pwm_i,
  output logic       enc_a_o,
  output logic       enc_b_o,
  output logic [15:0] hi_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] q_r = 2'b00;
  // One count, a quarter line, per request, gray coded
  always @(posedge clk_i)
    if (step_i) q_r <= up_i ? q_r + 2'd1 : q_r - 2'd1;
  assign enc_a_o = q_r[1];
  assign enc_b_o = q_r[1] ^ q_r[0];
  // Winding on-time counter
  initial hi_cnt_o = 16'h0;
  always @(posedge clk_i) if (pwm_i) hi_cnt_o <= hi_cnt_o + 16'h1;
endmodule

/* File: tb/dcpid_regulator_tb.sv */
// Self-checking bench of the DC motor position regulator
module dcpid_regulator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LC = 200;
  localparam int PC = 16;
  logic        clk_i = 0, rst_n_i = 0, ce_i = 1, wr_i = 0, rd_i = 0;
  logic        limit_stop_i = 0, step_i = 0, up_i = 0;
  logic        enc_a, enc_b, pwm_o, dir_o, move_done_o;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, got, r0, r1;
  logic [15:0] supply_mv_i = 16'h2EE0, seed = 16'h019F, hi_cnt, h0;
  logic [7:0]  ra [7] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h2C};
  logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h0, 32'h0000_2EE0,
                          32'h0000_0400, 32'h0, 32'h0000_0001};
  int          miscompares = 0, tests_run = 0;
  longint      kp = 1, unom = 12000, sup = 12000, cpr = 1, tgt = 0, meas = 0;
  longint      tl [4] = '{256, 128, -128, 1000};
  // Clock
  always #5 clk_i = ~clk_i;
  dcpid_regulator #(.LOOP_CYC(LC), .PWM_CYC(PC)) u_dcpid_regulator (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .enc_a_i(enc_a),
    .enc_b_i(enc_b), .supply_mv_i(supply_mv_i),
    .limit_stop_i(limit_stop_i), .rdata_o(rdata_o), .pwm_o(pwm_o),
    .dir_o(dir_o), .move_done_o(move_done_o));
  dcpid_motor_model u_dcpid_motor_model (.clk_i(clk_i), .step_i(step_i),
    .up_i(up_i), .pwm_i(pwm_o), .enc_a_o(enc_a), .enc_b_o(enc_b),
    .hi_cnt_o(hi_cnt));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] exp_duty(input longint u);
    if (u < 0) u = -u;
    u = u * unom / (sup * cpr);
    return (u > 65536) ? 32'h0001_0000 : 32'(u);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, got);
    chk(got, e);
  endtask
  task automatic settle();
    repeat (3 * LC + 100) @(posedge clk_i);
  endtask
  task automatic enc(input int n);
    repeat (n < 0 ? -n : n) begin
      @(posedge clk_i);
      step_i <= 1'b1;
      up_i <= n > 0;
      @(posedge clk_i);
      step_i <= 1'b0;
    end
    meas += n;
  endtask
  task automatic apply(input longint t);
    wr(8'h18, 32'(t));
    tgt = t;
    settle();
    rchk(8'h28, exp_duty(kp * (tgt - meas) * 256));
    chk({31'h0, dir_o}, {31'h0, tgt < meas});
  endtask
  task automatic reset_check();
    for (int i = 0; i < 7; i++) rchk(ra[i], rv[i]);
    $display("test reset values done");
  endtask
  task automatic close_out();
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    close_out();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    reset_check();
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      wr(8'(4 + 4 * i), {seed, ~seed});
      rchk(8'(4 + 4 * i), {16'h0, ~seed});
    end
    wr(8'h34, 32'h1234_5678);
    rchk(8'h34, 32'h0);
    wr(8'h20, 32'h0000_0005);
    rchk(8'h20, 32'h0);
    wr(8'h04, 32'h1);
    wr(8'h08, 32'h0);
    wr(8'h0C, 32'h0);
    wr(8'h10, 32'h0000_2EE0);
    wr(8'h14, 32'h1);
    wr(8'h1C, 32'h0001_0000);
    wr(8'h00, 32'h1);
    foreach (tl[i]) apply(tl[i]);
    rchk(8'h2C, 32'h0000_0002);
    $display("test proportional scaling done");
    @(posedge clk_i);
    supply_mv_i <= 16'h5DC0;
    sup = 24000;
    apply(256);
    h0 = hi_cnt;
    repeat (10 * PC) @(negedge clk_i);
    chk({16'h0, 16'(hi_cnt - h0)}, 32'd80);
    @(posedge clk_i);
    supply_mv_i <= 16'h2EE0;
    sup = 12000;
    enc(5);
    enc(-2);
    rchk(8'h24, 32'h3);
    apply(256);
    wr(8'h18, 32'h3);
    settle();
    chk({31'h0, move_done_o}, 32'h1);
    enc(1);
    repeat (4) @(posedge clk_i);
    chk({31'h0, move_done_o}, 32'h0);
    $display("test encoder and done done");
    wr(8'h1C, 32'h5);
    wr(8'h18, 32'h0000_1000);
    rd(8'h20, r0);
    repeat (LC - 2) @(posedge clk_i);
    rd(8'h20, r1);
    chk(r1 - r0, 32'h5);
    wr(8'h00, 32'h3);
    rd(8'h20, r0);
    rchk(8'h18, r0);
    repeat (2 * LC) @(posedge clk_i);
    rchk(8'h20, r0);
    wr(8'h18, r0 + 32'd500);
    limit_stop_i <= 1'b1;
    repeat (2 * LC) @(posedge clk_i);
    rd(8'h20, r1);
    rchk(8'h18, r1);
    repeat (LC) @(posedge clk_i);
    rchk(8'h20, r1);
    @(posedge clk_i);
    limit_stop_i <= 1'b0;
    $display("test stop and tracking done");
    wr(8'h00, 32'h0);
    settle();
    rchk(8'h28, 32'h0);
    // Integral: error 500 for exactly two ticks, 1 rev-s per 1000
    wr(8'h1C, 32'h0001_0000);
    wr(8'h18, 32'(meas));
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h1);
    settle();
    wr(8'h00, 32'h1);
    wr(8'h18, 32'(meas + 500));
    repeat (2 * LC - 2) @(posedge clk_i);
    wr(8'h18, 32'(meas));
    settle();
    rchk(8'h28, exp_duty(1000 * 65536 / 52500));
    // Derivative: error grows 4 counts per 1 ms tick
    wr(8'h08, 32'h0);
    wr(8'h0C, 32'h1);
    wr(8'h14, 32'h5);
    cpr = 5;
    wr(8'h1C, 32'h4);
    wr(8'h18, 32'h0001_0000);
    settle();
    rchk(8'h28, exp_duty(longint'(4) * 65536 * 60000 / 96000));
    $display("test integral and derivative done");
    @(posedge clk_i);
    ce_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    ce_i <= 1'b1;
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    reset_check();
    close_out();
  end
endmodule
bind dcpid_regulator dcpid_regulator_checker #(.LOOP_CYC(LOOP_CYC),
  .PWM_CYC(PWM_CYC), .AW(AW)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .enc_a_i(enc_a_i), .enc_b_i(enc_b_i),
  .supply_mv_i(supply_mv_i), .limit_stop_i(limit_stop_i),
  .rdata_o(rdata_o), .pwm_o(pwm_o), .dir_o(dir_o),
  .move_done_o(move_done_o));
